// ===== design/dasc_top.v
/*
 * Dual asynchronous serial channel with AXI4-Lite register slave,
 * clock source select, shared prescaler and per-channel power-of-two
 * baud generators, transmitters and receivers.
 * Assumes one clock mclk; serial inputs, clear-to-send and the external
 * baud clock are asynchronous pins and are synchronised here.
 */
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dasc_consts.vh"

// Function
// - Frame: start, data LSB first, parity, stops.
// - Start only when enabled, clear-to-send low, idle.
// - After start bit: busy, ready; load clears empty.
// - Waiting character follows stop bits immediately.
// - Started character completes; busy clears after.
// - Start valid after four successive low samples.
// - Data sampled at bit centres, eighth rate.
// - Parity checked; first stop checked for framing.
// - Received character zero-padded, ready flag set.
// - Unread buffer overwritten sets overrun.
// - All-zero frame sets break, waits for high.
// - Errors sticky until clear command; reception continues.
// - Interrupt: global mask zero, receive or transmit term.
// - Receive term: enabled, ready/break or errors, masks.
// - Priority: error, receive full, transmit empty.
// - Clock source select and 8-bit prescaler.
// - Power-of-two baud divider, then divide by eight.
// - Reset or init bit holds block until cleared.
// - Register reset values as specified.
// - Mode register field decode.
// - Command register field decode.
// - Ready and empty flag meanings.
module dasc_top (
	input  wire        mclk,
	input  wire        rstn,
	input  wire        ext_baud_clk,
	input  wire [1:0]  rxd,
	output wire [1:0]  txd,
	input  wire [1:0]  cts_n,
	output wire        rts_n,
	output wire [1:0]  irq,
	output wire [3:0]  irq_cause0,
	output wire [3:0]  irq_cause1,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ************************************************************
	// Reset release and pin synchronisers
	// ************************************************************
	reg  [1:0] rst_sync_r;
	reg  [4:0] pin_s1_r;
	reg  [4:0] pin_s2_r;
	wire       rst_n_int = rst_sync_r[1];

	// Reset is released through two flops; pins pass two flops.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
			pin_s1_r   <= 5'h1F;
			pin_s2_r   <= 5'h1F;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
			pin_s1_r   <= {ext_baud_clk, cts_n, rxd};
			pin_s2_r   <= pin_s1_r;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	reg  [7:0]  ctrl_r;
	reg  [7:0]  presc_r;
	reg  [7:0]  mode_r [0:1];
	reg  [7:0]  cmd_r  [0:1];
	reg  [7:0]  baud_r [0:1];
	reg  [7:0]  txbuf_r [0:1];
	reg  [7:0]  rxbuf_r [0:1];
	reg  [1:0]  txfull_r, rx_ready_flag_r, pe_r, oe_r, fe_r, brk_r;
	reg         aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	reg  [7:0]  awaddr_r;
	reg  [31:0] wdata_r, rdata_r;
	reg  [1:0]  rresp_r, bresp_r;
	reg  [1:0]  set_rdy, set_pe, set_fe, set_brk;
	reg  [1:0]  take_tx;
	reg  [7:0]  rx_char [0:1];

	wire blk_rst = ~rst_n_int | ctrl_r[`DASC_CTRL_INIT];

	wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
	wire do_rd = s_axi_arvalid & ~rvalid_r;
	assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// Decodes an address into a register slot; 4'hF means unmapped.
	function [3:0] dec_addr;
		input [7:0] a;
		begin
			case (a)
			`DASC_OFS_CTRL:                       dec_addr = 4'h0;
			`DASC_OFS_PRESC:                      dec_addr = 4'h1;
			`DASC_OFS_MODE0:                      dec_addr = 4'h2;
			`DASC_OFS_CMD0:                       dec_addr = 4'h3;
			`DASC_OFS_BAUD0:                      dec_addr = 4'h4;
			`DASC_OFS_STAT0:                      dec_addr = 4'h5;
			`DASC_OFS_DATA0:                      dec_addr = 4'h6;
			`DASC_OFS_MODE0 + `DASC_CH_STRIDE:    dec_addr = 4'hA;
			`DASC_OFS_CMD0 + `DASC_CH_STRIDE:     dec_addr = 4'hB;
			`DASC_OFS_BAUD0 + `DASC_CH_STRIDE:    dec_addr = 4'hC;
			`DASC_OFS_STAT0 + `DASC_CH_STRIDE:    dec_addr = 4'hD;
			`DASC_OFS_DATA0 + `DASC_CH_STRIDE:    dec_addr = 4'hE;
			default:                              dec_addr = 4'hF;
			endcase
		end
	endfunction

	wire [3:0] wsel = dec_addr(awaddr_r);
	wire [3:0] rsel = dec_addr(s_axi_araddr);
	wire       wch  = wsel[3];
	wire       rch  = rsel[3];
	wire       wen  = do_wr;
	wire [1:0] tx_ready_flag;
	wire [1:0] tx_idle_empty;
	wire [7:0] stat0 = {1'b0, brk_r[0], fe_r[0], oe_r[0], pe_r[0],
		tx_idle_empty[0], rx_ready_flag_r[0], tx_ready_flag[0]};
	wire [7:0] stat1 = {1'b0, brk_r[1], fe_r[1], oe_r[1], pe_r[1],
		tx_idle_empty[1], rx_ready_flag_r[1], tx_ready_flag[1]};
	wire       rd_data0 = do_rd & (rsel == 4'h6);
	wire       rd_data1 = do_rd & (rsel == 4'hE);

	// AXI4-Lite channel capture and answers; unmapped answers SLVERR.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			rvalid_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= 2'h0;
			bresp_r   <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (wsel == 4'hF) ? 2'h2 : 2'h0;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (do_rd) begin
				rvalid_r <= 1'b1;
				rresp_r  <= (rsel == 4'hF) ? 2'h2 : 2'h0;
				case (rsel[2:0])
				3'h0:    rdata_r <= {24'h0, ctrl_r};
				3'h1:    rdata_r <= {24'h0, presc_r};
				3'h2:    rdata_r <= {24'h0, mode_r[rch]};
				3'h3:    rdata_r <= {24'h0, cmd_r[rch] & 8'h2D};
				3'h4:    rdata_r <= {24'h0, baud_r[rch]};
				3'h5:    rdata_r <= {24'h0, rch ? stat1 : stat0};
				3'h6:    rdata_r <= {24'h0, rxbuf_r[rch]};
				default: rdata_r <= 32'h0000_0000;
				endcase
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Global control: only system reset forces its reset value.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r  <= `DASC_CTRL_RST;
			presc_r <= `DASC_PRESC_RST;
		end else if (!rst_n_int) begin
			ctrl_r  <= `DASC_CTRL_RST;
			presc_r <= `DASC_PRESC_RST;
		end else if (wen) begin
			if (wsel == 4'h0)
				ctrl_r <= wdata_r[7:0] & 8'hA1;
			if (wsel == 4'h1)
				presc_r <= wdata_r[7:0];
		end
	end

	// ************************************************************
	// Clock source, prescaler and baud generators
	// ************************************************************
	reg        extd_r;
	reg  [7:0] pcnt_r;
	wire       src_tick = ctrl_r[`DASC_CTRL_CKSEL] | (pin_s2_r[4] & ~extd_r);
	wire [7:0] plim = presc_r - 8'h01; // 0 wraps to 255: divide by 256.
	wire       ptick = src_tick & (pcnt_r == plim);

	// The external clock must run below half of mclk to be seen.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			extd_r <= 1'b1; // Matches the pin's reset level, so no false first tick.
			pcnt_r <= 8'h00;
		end else begin
			extd_r <= pin_s2_r[4];
			if (blk_rst)
				pcnt_r <= 8'h00;
			else if (ptick)
				pcnt_r <= 8'h00;
			else if (src_tick)
				pcnt_r <= pcnt_r + 8'h01;
		end
	end

	// ************************************************************
	// Per-channel transmitter and receiver
	// ************************************************************
	genvar ch;
	generate
	for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
		reg  [6:0] bcnt_r;
		reg  [2:0] tphase_r, rphase_r, scnt_r;
		reg        tx_busy_r, txd_r, tpar_r;
		reg  [3:0] tbit_r, rbit_r;
		reg  [7:0] tsh_r, rsh_r;
		reg        rpar_r, rzero_r, rwait_r;
		reg  [1:0] rst_r;
		wire [7:0] m  = mode_r[ch];
		wire [7:0] c  = cmd_r[ch];
		wire [3:0] dlen = {2'h0, m[3:2]} + 4'h5;
		wire [3:0] plen = dlen + {3'h0, m[`DASC_MODE_PAREN]};
		wire [3:0] flen = plen + 4'h1 + {3'h0, m[`DASC_MODE_STOP2]};
		wire       cts_lo = ~pin_s2_r[2 + ch];
		wire       rx_in  = pin_s2_r[ch];
		// One-hot baud bit n divides by 2^n: tick when the n low count bits are zero.
		wire [6:0] bmask = baud_r[ch][6:0] - 7'h01;
		wire       otick = ptick & ((bcnt_r & bmask) == 7'h00);
		wire       btick = otick & (tphase_r == `DASC_OVS_PER_BIT);
		wire       bufe  = ~txfull_r[ch];

		// Power-of-two divider: count prescaled ticks in binary.
		always @(posedge mclk or negedge rstn) begin
			if (!rstn)
				bcnt_r <= 7'h00;
			else if (blk_rst)
				bcnt_r <= 7'h00;
			else if (ptick)
				bcnt_r <= bcnt_r + 7'h01;
		end

		assign tx_idle_empty[ch] = bufe & ~tx_busy_r;
		assign tx_ready_flag[ch] = bufe & (m[`DASC_MODE_TXIM] |
			(cts_lo & c[`DASC_CMD_TX_ENABLE]));

		// Transmitter: frame index 0 is start, 1..flen data/parity/stop.
		always @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				tphase_r <= 3'h0;
				tx_busy_r <= 1'b0;
				txd_r <= 1'b1;
				tbit_r <= 4'h0;
				tsh_r <= 8'h00;
				tpar_r <= 1'b0;
				take_tx[ch] <= 1'b0;
			end else if (blk_rst) begin
				tphase_r <= 3'h0;
				tx_busy_r <= 1'b0;
				txd_r <= 1'b1;
				tbit_r <= 4'h0;
				tsh_r <= 8'h00;
				tpar_r <= 1'b0;
				take_tx[ch] <= 1'b0;
			end else begin
				take_tx[ch] <= 1'b0;
				if (otick)
					tphase_r <= tphase_r + 3'h1;
				if (btick) begin
					if ((!tx_busy_r || tbit_r == flen + 4'h1) && txfull_r[ch] &&
						c[`DASC_CMD_TX_ENABLE] && cts_lo) begin
						txd_r <= 1'b0;
						tsh_r <= txbuf_r[ch];
						tpar_r <= ^(txbuf_r[ch] & ~(8'hFF << dlen)) ^ m[`DASC_MODE_ODD];
						tbit_r <= 4'h1;
						tx_busy_r <= 1'b1;
						take_tx[ch] <= 1'b1;
					end else if (tx_busy_r && tbit_r == flen + 4'h1) begin
						tx_busy_r <= 1'b0;
						txd_r <= 1'b1;
					end else if (tx_busy_r) begin
						tbit_r <= tbit_r + 4'h1;
						if (tbit_r <= dlen) begin
							txd_r <= tsh_r[0];
							tsh_r <= {1'b0, tsh_r[7:1]};
						end else if (tbit_r == dlen + 4'h1 && m[`DASC_MODE_PAREN])
							txd_r <= tpar_r;
						else
							txd_r <= 1'b1;
					end
				end
			end
		end
		// Data bits shift from the loaded copy; parity uses it too.
		assign txd[ch] = txd_r & ~c[`DASC_CMD_BRK];

		// Receiver: idle, start qualification, then centre sampling.
		always @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				rst_r <= 2'h0;
				scnt_r <= 3'h0;
				rphase_r <= 3'h0;
				rbit_r <= 4'h0;
				rsh_r <= 8'h00;
				rpar_r <= 1'b0;
				rzero_r <= 1'b0;
				rwait_r <= 1'b0;
				{set_rdy[ch], set_pe[ch], set_fe[ch], set_brk[ch]} <= 4'h0;
				rx_char[ch] <= 8'h00;
			end else if (blk_rst || !c[`DASC_CMD_RX_ENABLE]) begin
				rst_r <= 2'h0;
				scnt_r <= 3'h0;
				rwait_r <= 1'b0;
				{set_rdy[ch], set_pe[ch], set_fe[ch], set_brk[ch]} <= 4'h0;
			end else begin
				{set_rdy[ch], set_pe[ch], set_fe[ch], set_brk[ch]} <= 4'h0;
				if (rwait_r && rx_in)
					rwait_r <= 1'b0;
				if (otick) begin
					case (rst_r)
					2'h0: begin
						if (!rx_in && !rwait_r) begin
							scnt_r <= 3'h1;
							rst_r <= 2'h1;
						end
					end
					2'h1: begin
						if (rx_in)
							rst_r <= 2'h0;
						else if (scnt_r == `DASC_START_SAMPLES - 3'h1) begin
							rst_r <= 2'h2;
							rphase_r <= 3'h0;
							rbit_r <= 4'h1;
							rsh_r <= 8'h00;
							rpar_r <= m[`DASC_MODE_ODD];
							rzero_r <= 1'b1;
						end else
							scnt_r <= scnt_r + 3'h1;
					end
					2'h2: begin
						rphase_r <= rphase_r + 3'h1;
						// Fourth sample sits half a bit in; centres every eight.
						if (rphase_r == `DASC_OVS_PER_BIT) begin
							rbit_r <= rbit_r + 4'h1;
							rzero_r <= rzero_r & ~rx_in;
							if (rbit_r <= dlen) begin
								rsh_r <= {rx_in, rsh_r[7:1]};
								rpar_r <= rpar_r ^ rx_in;
							end else if (rbit_r == plen && m[`DASC_MODE_PAREN]) begin
								set_pe[ch] <= rpar_r ^ rx_in;
							end
							if (rbit_r == plen + 4'h1) begin
								set_fe[ch] <= ~rx_in;
								set_rdy[ch] <= 1'b1;
								rx_char[ch] <= rsh_r >> (4'h8 - dlen);
								if (rzero_r && !rx_in) begin
									set_brk[ch] <= 1'b1;
									rwait_r <= 1'b1;
								end
								rst_r <= 2'h0;
							end
						end
					end
					default: rst_r <= 2'h0;
					endcase
				end
			end
		end
	end
	endgenerate

	// ************************************************************
	// Channel registers, buffers and sticky flags
	// ************************************************************
	integer i;
	// Hardware set wins over a clear in the same cycle.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (i = 0; i < 2; i = i + 1) begin
				mode_r[i] <= `DASC_MODE_RST;
				cmd_r[i] <= `DASC_CMD_RST;
				baud_r[i] <= `DASC_BAUD_RST;
				txbuf_r[i] <= 8'h00;
				rxbuf_r[i] <= 8'h00;
			end
			{txfull_r, rx_ready_flag_r, pe_r, oe_r, fe_r, brk_r} <= 12'h000;
		end else if (blk_rst) begin
			for (i = 0; i < 2; i = i + 1) begin
				cmd_r[i] <= `DASC_CMD_RST;
				rxbuf_r[i] <= 8'h00;
			end
			{txfull_r, rx_ready_flag_r, pe_r, oe_r, fe_r, brk_r} <= 12'h000;
			if (wen && wsel[2:0] == 3'h2)
				mode_r[wch] <= wdata_r[7:0];
			if (wen && wsel[2:0] == 3'h4)
				baud_r[wch] <= wdata_r[7:0];
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				if (take_tx[i])
					txfull_r[i] <= 1'b0;
				if (set_rdy[i]) begin
					rxbuf_r[i] <= rx_char[i];
					oe_r[i] <= oe_r[i] | rx_ready_flag_r[i];
				end
				if (wen && wch == i[0] && wsel[2:0] == 3'h3 && wdata_r[`DASC_CMD_CLR]) begin
					pe_r[i] <= 1'b0;
					fe_r[i] <= 1'b0;
					brk_r[i] <= 1'b0;
					if (!set_rdy[i])
						oe_r[i] <= 1'b0;
				end
				if (set_pe[i]) pe_r[i] <= 1'b1;
				if (set_fe[i]) fe_r[i] <= 1'b1;
				if (set_brk[i]) brk_r[i] <= 1'b1;
				if (set_rdy[i] && rx_ready_flag_r[i]) oe_r[i] <= 1'b1;
			end
			rx_ready_flag_r <= (rx_ready_flag_r & ~{rd_data1, rd_data0}) | set_rdy;
			if (wen && wsel[2:0] == 3'h2)
				mode_r[wch] <= wdata_r[7:0];
			if (wen && wsel[2:0] == 3'h3)
				cmd_r[wch] <= wdata_r[7:0] & 8'h3D;
			if (wen && wsel[2:0] == 3'h4)
				baud_r[wch] <= wdata_r[7:0];
			if (wen && wsel[2:0] == 3'h6) begin
				txbuf_r[wch] <= wdata_r[7:0];
				txfull_r[wch] <= 1'b1;
			end
		end
	end

	assign rts_n = ~cmd_r[0][`DASC_CMD_RTS];

	// ************************************************************
	// Interrupt combination and cause priority
	// ************************************************************
	wire [1:0] err_t, rxf_t, txe_t, rx_irq_term, tx_irq_term;
	generate
	for (ch = 0; ch < 2; ch = ch + 1) begin : g_irq
		assign err_t[ch] = cmd_r[ch][`DASC_CMD_RX_ENABLE] & ~mode_r[ch][`DASC_MODE_ERIM] &
			(fe_r[ch] | oe_r[ch] | pe_r[ch]);
		assign rxf_t[ch] = cmd_r[ch][`DASC_CMD_RX_ENABLE] & ~mode_r[ch][`DASC_MODE_RXIM] &
			(rx_ready_flag_r[ch] | brk_r[ch]);
		assign rx_irq_term[ch] = err_t[ch] | rxf_t[ch];
		assign tx_irq_term[ch] = cmd_r[ch][`DASC_CMD_TX_ENABLE] & ~pin_s2_r[2 + ch] &
			tx_ready_flag[ch] & ~mode_r[ch][`DASC_MODE_TXIM];
		assign txe_t[ch] = tx_irq_term[ch];
		assign irq[ch] = ~ctrl_r[`DASC_CTRL_GIM] & (rx_irq_term[ch] | tx_irq_term[ch]);
	end
	endgenerate

	// Highest pending cause only, one-hot: error, receive, transmit.
	assign irq_cause0 = {1'b0, err_t[0], rxf_t[0] & ~err_t[0],
		txe_t[0] & ~rx_irq_term[0]};
	assign irq_cause1 = {1'b0, err_t[1], rxf_t[1] & ~err_t[1],
		txe_t[1] & ~rx_irq_term[1]};

endmodule

`default_nettype wire

// ===== shared/dasc_consts.vh
/*
 * Constants for the dual asynchronous serial channel: register byte
 * offsets, field positions and reset values.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef DASC_CONSTS_VH
`define DASC_CONSTS_VH

// ************************************************************
// Register byte offsets on the AXI4-Lite slave
// ************************************************************
`define DASC_OFS_CTRL      8'h00
`define DASC_OFS_PRESC     8'h04
`define DASC_OFS_MODE0     8'h10
`define DASC_OFS_CMD0      8'h14
`define DASC_OFS_BAUD0     8'h18
`define DASC_OFS_STAT0     8'h1C
`define DASC_OFS_DATA0     8'h20
`define DASC_CH_STRIDE     8'h20

// ************************************************************
// Field positions
// ************************************************************
`define DASC_CTRL_GIM      0
`define DASC_CTRL_INIT     5
`define DASC_CTRL_CKSEL    7
`define DASC_MODE_STOP2    0
`define DASC_MODE_TXIM     1
`define DASC_MODE_PAREN    4
`define DASC_MODE_ODD      5
`define DASC_MODE_ERIM     6
`define DASC_MODE_RXIM     7
`define DASC_CMD_TX_ENABLE      0
`define DASC_CMD_RX_ENABLE      2
`define DASC_CMD_BRK       3
`define DASC_CMD_CLR       4
`define DASC_CMD_RTS       5

// ************************************************************
// Reset values and counts
// ************************************************************
`define DASC_CTRL_RST      8'hA1
`define DASC_CMD_RST       8'h10
`define DASC_MODE_RST      8'h00
`define DASC_BAUD_RST      8'h01
`define DASC_PRESC_RST     8'h01
`define DASC_START_SAMPLES 3'h4
`define DASC_OVS_PER_BIT   3'h7
`define DASC_MID_OFFSET    3'h3

`endif

// ===== sim/dasc_bench.sv
/* Self-checking bench for dasc_top, channel 0, against the remote device model.
   Assumes prescaler and baud reset to divide by one: one bit is 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module dasc_bench;
	logic        mclk = 1'h0;
	logic        rstn = 1'h0;
	logic [1:0]  rxd, txd, cts_n, irq, bresp, rresp, resp;
	logic        rts_n, awready, wready, bvalid, arready, rvalid;
	logic [3:0]  cause0, cause1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	int          n_errors = 0, n_checks = 0;
	// Free-running 10 MHz clock; the external baud clock runs at a quarter of it.
	logic        bclk = 1'h0;
	always #50 mclk = ~mclk;
	always #200 bclk = ~bclk;
	dasc_partner part (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
	dasc_top dut (.mclk(mclk), .rstn(rstn), .ext_baud_clk(bclk), .rxd(rxd), .txd(txd),
		.cts_n(cts_n), .rts_n(rts_n), .irq(irq), .irq_cause0(cause0), .irq_cause1(cause1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Both write channels offered together; each released once taken.
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [7:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata[7:0];
		resp = rresp;
		rready <= 1'h0;
		@(posedge mclk);
	endtask
	// Expected line bits of one character under mode m; n returns the bit count.
	function automatic logic [15:0] frame(input logic [7:0] m, input logic [7:0] d, output int n);
		logic p;
		p = m[5];
		frame = 16'h0;
		for (n = 1; n <= 5 + m[3:2]; n++) begin
			frame[n] = d[n - 1];
			p = p ^ d[n - 1];
		end
		if (m[4]) begin
			frame[n] = p;
			n++;
		end
		frame[n] = 1'h1;
		frame[n + 1] = m[0];
		n = n + 1 + m[0];
	endfunction
	// Partner sends one character, optionally corrupted by x; status returned.
	task automatic rxf(input logic [7:0] m, input logic [7:0] d, input logic [15:0] x,
		output logic [7:0] s);
		int n;
		logic [15:0] f;
		f = frame(m, d, n);
		part.send(n, f ^ x, 8);
		repeat (24) @(posedge mclk);
		axr(8'h1C, s);
	endtask
	task automatic sc_init;
		logic [7:0] d;
		int lows;
		axr(8'h00, d);
		chk(d, 8'hA1);
		axr(8'h1C, d);
		chk(d, 8'h04);
		axr(8'hF0, d);
		chk({resp, d}, 10'h200);
		part.cts(1'h0);
		axw(8'h14, 8'h01);
		axw(8'h20, 8'h55);
		lows = 0;
		repeat (200) @(posedge mclk) lows += (txd[0] !== 1'h1);
		chk(lows, 0);
		axw(8'h00, 8'h80);
		axr(8'h1C, d);
		chk(d, 8'h04);
	endtask
	// Two back-to-back characters per mode; second mode uses slower dividers,
	// the third runs from the external baud clock.
	task automatic sc_tx;
		logic [7:0] m [3] = '{8'h1C, 8'h31, 8'h1C};
		logic [15:0] f1, f2;
		logic [7:0] d;
		time t1, t2;
		int n, len;
		for (int i = 0; i < 3; i++) begin
			len = (i == 0) ? 8 : 32;
			axw(8'h00, (i == 2) ? 8'h00 : 8'h80);
			axw(8'h04, 8'h01 + i[0]);
			axw(8'h18, 8'h01 << i[0]);
			axw(8'h10, m[i]);
			axw(8'h14, 8'h01);
			f1 = frame(m[i], 8'hA5, n);
			fork
				begin
					part.catch(n, len, f1, t1);
					part.catch(n, len, f2, t2);
				end
				begin
					axw(8'h20, 8'hA5);
					for (int k = 0; k < 900 && txd[0] !== 1'h0; k++) @(posedge mclk);
					repeat (len + 2) @(posedge mclk);
					axw(8'h20, 8'h3C);
					axr(8'h1C, d);
					chk(d[2:0], 3'h0);
				end
			join
			chk(f1, frame(m[i], 8'hA5, n));
			chk(f2, frame(m[i], 8'h3C, n));
			chk(t2 - t1, n * len * 100);
		end
		axw(8'h04, 8'h01);
		axw(8'h18, 8'h01);
		axw(8'h00, 8'h80);
	endtask
	task automatic sc_cts;
		logic [15:0] f;
		logic [7:0] d;
		time t;
		int n, lows;
		axw(8'h10, 8'h1C);
		fork
			part.catch(11, 8, f, t);
			begin
				axw(8'h20, 8'h96);
				repeat (30) @(posedge mclk);
				part.cts(1'h1);
				axw(8'h14, 8'h00);
			end
		join
		chk(f, frame(8'h1C, 8'h96, n));
		axw(8'h14, 8'h01);
		axw(8'h20, 8'h69);
		lows = 0;
		repeat (300) @(posedge mclk) lows += (txd[0] !== 1'h1);
		chk(lows, 0);
		axr(8'h1C, d);
		chk(d[2:0], 3'h0);
		fork
			part.catch(11, 8, f, t);
			part.cts(1'h0);
		join
		chk(f, frame(8'h1C, 8'h69, n));
		repeat (8) @(posedge mclk);
		chk({irq, cause0}, 6'h11);
		axw(8'h00, 8'h81);
		chk(irq, 2'h0);
		axw(8'h00, 8'h80);
		axw(8'h14, 8'h08);
		chk(txd[0], 1'h0);
		repeat (8) @(posedge mclk);
		axw(8'h14, 8'h00);
	endtask
	task automatic sc_rx;
		logic [7:0] s, d;
		axw(8'h10, 8'h1E);
		axw(8'h14, 8'h24);
		chk(rts_n, 1'h0);
		part.send(1, 16'h0, 3);
		repeat (100) @(posedge mclk);
		axr(8'h1C, s);
		chk(s, 8'h05);
		rxf(8'h1E, 8'hA5, 16'h0, s);
		chk(s, 8'h07);
		chk(cause0, 4'h2);
		axr(8'h20, d);
		chk(d, 8'hA5);
		axw(8'h10, 8'h12);
		rxf(8'h12, 8'hFF, 16'h0, s);
		axr(8'h20, d);
		chk(d, 8'h1F);
		axw(8'h10, 8'h1E);
		rxf(8'h1E, 8'hA5, 16'h0200, s);
		chk(s & 8'h7A, 8'h0A);
		chk(cause0, 4'h4);
		rxf(8'h1E, 8'h3C, 16'h0, s);
		chk(s & 8'h7A, 8'h1A);
		axr(8'h20, d);
		chk(d, 8'h3C);
		part.send(16, 16'h0, 8);
		repeat (16) @(posedge mclk);
		rxf(8'h1E, 8'h5A, 16'h0, s);
		chk(s & 8'h78, 8'h78);
		axr(8'h20, d);
		chk(d, 8'h5A);
		axw(8'h10, 8'h5E);
		chk(cause0, 4'h2);
		axw(8'h14, 8'h14);
		axr(8'h1C, s);
		chk(s & 8'h7A, 8'h00);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence after 8 cycles of reset.
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'h1;
		repeat (4) @(posedge mclk);
		sc_init;
		sc_tx;
		sc_cts;
		sc_rx;
		results;
	end
	// Watchdog: the sequence needs well under 20000 cycles.
	initial begin
		#3000000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire

// ===== sim/dasc_chk.sv
/* Checker for dasc_top: bus handshakes, start bit length, interrupt causes.
   Assumes a bind to dasc_top and a bit time of at least 8 mclk cycles. */
`timescale 1ns/1ps
`default_nettype none
module dasc_chk (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [1:0]  txd,
	input wire logic [1:0]  irq,
	input wire logic [3:0]  irq_cause0,
	input wire logic [3:0]  irq_cause1,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	// One clock domain, so clocking and disable are declared once.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken during answer");
	chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_start_bit: assert property ($fell(txd[0]) |-> !txd[0] [*8])
		else $error("start bit too short");
	chk_cause0_single: assert property (irq[0] |-> irq_cause0 inside {4'h1, 4'h2, 4'h4})
		else $error("channel 0 cause not single");
	chk_cause1_single: assert property (irq[1] |-> irq_cause1 inside {4'h1, 4'h2, 4'h4})
		else $error("channel 1 cause not single");
endmodule
bind dasc_top dasc_chk u_chk (.mclk(mclk), .rstn(rstn), .txd(txd), .irq(irq),
	.irq_cause0(irq_cause0), .irq_cause1(irq_cause1), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata));
`default_nettype wire

// ===== sim/dasc_partner.sv
/* Remote serial device on channel 0: drives rxd and clear-to-send, samples txd.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dasc_partner (
	input  wire logic       mclk,
	input  wire logic [1:0] txd,
	output var  logic [1:0] rxd,
	output var  logic [1:0] cts_n
);
	// Lines idle at mark; channel 1 stays quiet and not cleared to send.
	initial begin
		rxd = 2'h3;
		cts_n = 2'h3;
	end
	// Clear-to-send for channel 0.
	task automatic cts(input logic v);
		cts_n[0] <= v;
	endtask
	// Sends n bits first bit first, each held len cycles; the line returns to mark.
	task automatic send(input int n, input logic [15:0] f, input int len);
		for (int i = 0; i < n; i++) begin
			rxd[0] <= f[i];
			repeat (len) @(posedge mclk);
		end
		rxd[0] <= 1'h1;
	endtask
	// Waits for a start edge, then samples each bit at its centre.
	task automatic catch(input int n, input int len, output logic [15:0] f, output time t0);
		int k;
		f = 16'h0;
		k = 0;
		while (txd[0] !== 1'h0 && k < 9000) begin
			@(posedge mclk);
			k++;
		end
		t0 = $time;
		for (int i = 0; i < n; i++) begin
			repeat (len / 2) @(posedge mclk);
			f[i] = txd[0];
			repeat (len - len / 2) @(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire
